// *** rtl/dtlbro_pkg.sv ***
// package: constants and types for the data tlb read-out and fault block
package dtlbro_pkg;

    // ==========================================
    // special register numbers (chosen)
    localparam logic [9:0] SPR_TAG_SNAPSHOT = 10'h318;
    localparam logic [9:0] SPR_DATA_SNAPSHOT_0 = 10'h319;
    localparam logic [9:0] SPR_DATA_SNAPSHOT_1 = 10'h31A;
    localparam logic [9:0] SPR_CURRENT_SPACE = 10'h315;

    // ==========================================
    // tag snapshot fields (bit 0 is msb, so lsb index = 31 - big-endian index)
    localparam int TAG_PAGE_LSB = 12;
    localparam int TAG_SUBVALID_LSB = 8;
    localparam int TAG_SIZE_LSB = 5;
    localparam int TAG_COMMON_POS = 4;
    localparam int TAG_SPACE_LSB = 0;

    // ==========================================
    // data snapshot 0 fields
    localparam int D0_REAL_LSB = 12;
    localparam int D0_SIZE_LSB = 9;
    localparam int D0_GROUP_LSB = 5;
    localparam int D0_G_POS = 4;
    localparam int D0_WTHRU_POS = 3;
    localparam int D0_NOCACHE_POS = 2;

    // ==========================================
    // data snapshot 1 fields
    localparam int D1_C_POS = 14;
    localparam int D1_VALID_POS = 13;
    localparam int D1_PRIV_LSB = 9;
    localparam int D1_PRIVTYPE_POS = 8;
    localparam int D1_UPERM_LSB = 0;

    // ==========================================
    // page size codes
    localparam logic [2:0] SIZE_4K = 3'h0;
    localparam logic [2:0] SIZE_16K = 3'h1;
    localparam logic [2:0] SIZE_512K = 3'h3;
    localparam logic [2:0] SIZE_8M = 3'h7;

    // ==========================================
    // reset values
    localparam logic [3:0] CURRENT_SPACE_RST = 4'h0;

    // ==========================================
    // one data tlb entry
    typedef struct packed {
        logic [19:0] effective_page_number;
        logic [3:0] subpage_valid_flags;
        logic [2:0] page_size_code;
        logic common_page_flag;
        logic [3:0] address_space_id;
        logic [19:0] real_page_number;
        logic [3:0] apg;
        logic guarded;
        logic write_through_attr;
        logic no_cache_attr;
        logic change;
        logic entry_valid_flag;
        logic [3:0] priv_subpage_access;
        logic priv_rw_type;
        logic [7:0] uperm;
    } dtlbro_entry_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_LOAD = 2'b01
    } dtlbro_state_t;

endpackage

// *** rtl/dtlbro_snap_if.sv ***
// interface: entry read port between entry storage and snapshot unit
`timescale 1ns/10ps
interface dtlbro_snap_if;
    logic capture;
    dtlbro_pkg::dtlbro_entry_t entry;
    logic [31:0] tag_word;
    logic [31:0] data0_word;
    logic [31:0] data1_word;
    modport ctrl (output capture, output entry, input tag_word, input data0_word, input data1_word);
    modport snap (input capture, input entry, output tag_word, output data0_word, output data1_word);
endinterface

// *** rtl/dtlbro_snapshot.sv ***
// snapshot unit: packs a tlb entry into the three read-out words
`timescale 1ns/10ps
module dtlbro_snapshot (
    // clock
    input wire logic ref_clk,
    // port
    dtlbro_snap_if.snap sp
);
    // ==========================================
    // capture, no reset, held until next capture
    logic [31:0] tag_ff;
    logic [31:0] d0_ff;
    logic [31:0] d1_ff;

    always_ff @(posedge ref_clk) begin
        if (sp.capture) begin // RULE1 RULE4 RULE22
            tag_ff <= 32'h0;
            tag_ff[dtlbro_pkg::TAG_PAGE_LSB +: 20] <= sp.entry.effective_page_number;
            tag_ff[dtlbro_pkg::TAG_SUBVALID_LSB +: 4] <= {sp.entry.subpage_valid_flags[0],
                sp.entry.subpage_valid_flags[1], sp.entry.subpage_valid_flags[2],
                sp.entry.subpage_valid_flags[3]}; // RULE5
            tag_ff[dtlbro_pkg::TAG_SIZE_LSB +: 3] <= sp.entry.page_size_code; // RULE6
            tag_ff[dtlbro_pkg::TAG_COMMON_POS] <= sp.entry.common_page_flag;
            tag_ff[dtlbro_pkg::TAG_SPACE_LSB +: 4] <= sp.entry.address_space_id;
            d0_ff <= 32'h0; // RULE9
            d0_ff[dtlbro_pkg::D0_REAL_LSB +: 20] <= sp.entry.real_page_number;
            d0_ff[dtlbro_pkg::D0_SIZE_LSB +: 3] <= sp.entry.page_size_code;
            d0_ff[dtlbro_pkg::D0_GROUP_LSB +: 4] <= ~sp.entry.apg; // RULE10
            d0_ff[dtlbro_pkg::D0_G_POS] <= sp.entry.guarded; // RULE11
            d0_ff[dtlbro_pkg::D0_WTHRU_POS] <= sp.entry.write_through_attr; // RULE12
            d0_ff[dtlbro_pkg::D0_NOCACHE_POS] <= sp.entry.no_cache_attr;
            d1_ff <= 32'h0;
            d1_ff[dtlbro_pkg::D1_C_POS] <= sp.entry.change;
            d1_ff[dtlbro_pkg::D1_VALID_POS] <= sp.entry.entry_valid_flag; // RULE14
            d1_ff[dtlbro_pkg::D1_PRIV_LSB +: 4] <= {sp.entry.priv_subpage_access[0],
                sp.entry.priv_subpage_access[1], sp.entry.priv_subpage_access[2],
                sp.entry.priv_subpage_access[3]}; // RULE15
            d1_ff[dtlbro_pkg::D1_PRIVTYPE_POS] <= sp.entry.priv_rw_type; // RULE16
            d1_ff[dtlbro_pkg::D1_UPERM_LSB +: 8] <= sp.entry.uperm; // RULE17
        end
    end

    assign sp.tag_word = tag_ff;
    assign sp.data0_word = d0_ff;
    assign sp.data1_word = d1_ff;
endmodule

// *** rtl/dtlbro_top.sv ***
// top: data tlb entry store, read-out registers and tlb fault signalling
// Operation
// RULE1: writing tag read-out copies the indexed data tlb entry into all three read-outs
// RULE2: the written data value is ignored; the write itself triggers capture
// RULE3: writes to either data read-out register change nothing
// RULE4: read-out registers are not reset; undefined until first capture
// RULE5: tag bits 20 to 23 flag validity of the four 1k subpages
// RULE6: page size code 000 4k, 001 16k, 011 512k, 111 8m
// RULE7: unshared entries match only on equal space id; shared skip it
// RULE8: space id compares against the current-space field
// RULE9: data read-out 0 holds page, size, group, attributes; bits 30-31 zero
// RULE10: protection group reads as its bitwise inverse
// RULE11: guarded bit reads 1 for guarded storage
// RULE12: writethrough bit reads 1 for writethrough, 0 for copyback
// RULE13: write to page with clear change bit raises tlb fault
// RULE14: entry valid flag reads 1 for valid entry
// RULE15: bits 19 to 22 grant privileged access per subpage
// RULE16: privileged type bit 0 read-only, 1 read and write
// RULE17: bits 24 to 31 alternate user read and write per subpage
// RULE18: translated fetch missing the instruction tlb raises instruction miss
// RULE19: translated data access missing the data tlb raises data miss
// RULE20: instruction error on invalid page, protection fault or guarded fetch
// RULE21: instruction error cause is recorded in save/restore register 1
// RULE22: read-outs keep their snapshot until the next tag write
`timescale 1ns/10ps
module dtlbro_top #(
    parameter int ENTRIES = 32,
    parameter int IDX_W = $clog2(ENTRIES)
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // special register move port
    input wire logic spr_wr,
    input wire logic spr_rd,
    input wire logic [9:0] spr_num,
    input wire logic [31:0] spr_wdata,
    output logic [31:0] spr_rdata,
    // entry index from control register
    input wire logic [IDX_W-1:0] data_entry_index,
    // data tlb entry load port
    input wire logic entry_load,
    input wire dtlbro_pkg::dtlbro_entry_t entry_in,
    // data access lookup
    input wire logic data_xlate_enable,
    input wire logic data_req,
    input wire logic data_write,
    input wire logic [19:0] data_page,
    // instruction fetch lookup result
    input wire logic instr_xlate_enable,
    input wire logic fetch_req,
    input wire logic itlb_hit,
    input wire logic itlb_page_valid,
    input wire logic itlb_prot_viol,
    input wire logic itlb_guarded,
    // interrupt requests, error cause and current space field
    output logic itlb_miss_irq,
    output logic dtlb_miss_irq,
    output logic itlb_error_irq,
    output logic dtlb_fault_irq,
    output logic [3:0] itlb_error_cause,
    output logic [3:0] current_space_field
);
    if (ENTRIES < 1 || ENTRIES > (1 << IDX_W)) begin : g_bad_entries
        $error("dtlbro_top: bad ENTRIES");
    end

    // ==========================================
    // entry storage
    dtlbro_pkg::dtlbro_entry_t mem_ff [ENTRIES];

    always_ff @(posedge ref_clk) begin
        if (entry_load)
            mem_ff[data_entry_index] <= entry_in;
    end

    // ==========================================
    // current space register
    logic [3:0] space_ff;
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst)
            space_ff <= dtlbro_pkg::CURRENT_SPACE_RST;
        else if (spr_wr && spr_num == dtlbro_pkg::SPR_CURRENT_SPACE)
            space_ff <= spr_wdata[3:0];
    end
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst)
            current_space_field <= 4'h0;
        else
            current_space_field <= space_ff;
    end

    // ==========================================
    // snapshot trigger
    dtlbro_snap_if sif ();
    logic tag_wr;
    assign tag_wr = spr_wr && spr_num == dtlbro_pkg::SPR_TAG_SNAPSHOT; // RULE1 RULE2
    assign sif.capture = tag_wr;
    assign sif.entry = mem_ff[data_entry_index];

    dtlbro_snapshot u_snap (
        .ref_clk(ref_clk),
        .sp(sif.snap)
    );

    // ==========================================
    // read mux; data read-out writes fall through as no-ops
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            spr_rdata <= 32'h0;
        end else if (spr_rd) begin // RULE3
            case (spr_num)
                dtlbro_pkg::SPR_TAG_SNAPSHOT: spr_rdata <= sif.tag_word;
                dtlbro_pkg::SPR_DATA_SNAPSHOT_0: spr_rdata <= sif.data0_word;
                dtlbro_pkg::SPR_DATA_SNAPSHOT_1: spr_rdata <= sif.data1_word;
                dtlbro_pkg::SPR_CURRENT_SPACE: spr_rdata <= {28'h0, space_ff};
                default: spr_rdata <= 32'h0;
            endcase
        end
    end

    // ==========================================
    // data lookup
    logic [ENTRIES-1:0] hit_vec;
    logic [ENTRIES-1:0] nochg_vec;
    genvar g;
    generate
        for (g = 0; g < ENTRIES; g++) begin : g_match
            logic [19:0] mask;
            always_comb begin
                case (mem_ff[g].page_size_code) // RULE6
                    dtlbro_pkg::SIZE_16K: mask = 20'hFFFFC;
                    dtlbro_pkg::SIZE_512K: mask = 20'hFFF80;
                    dtlbro_pkg::SIZE_8M: mask = 20'hFF800;
                    default: mask = 20'hFFFFF;
                endcase
            end
            assign hit_vec[g] = mem_ff[g].entry_valid_flag &&
                ((mem_ff[g].effective_page_number & mask) == (data_page & mask)) &&
                (mem_ff[g].common_page_flag || mem_ff[g].address_space_id == space_ff); // RULE7 RULE8
            assign nochg_vec[g] = hit_vec[g] && !mem_ff[g].change;
        end
    endgenerate

    // ==========================================
    // fault outputs
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            dtlb_miss_irq <= 1'b0;
            dtlb_fault_irq <= 1'b0;
        end else begin
            dtlb_miss_irq <= data_xlate_enable && data_req && hit_vec == '0; // RULE19
            dtlb_fault_irq <= data_xlate_enable && data_req && data_write && |nochg_vec; // RULE13
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            itlb_miss_irq <= 1'b0;
            itlb_error_irq <= 1'b0;
            itlb_error_cause <= 4'h0;
        end else begin
            itlb_miss_irq <= instr_xlate_enable && fetch_req && !itlb_hit; // RULE18
            itlb_error_irq <= instr_xlate_enable && fetch_req && itlb_hit &&
                (!itlb_page_valid || itlb_prot_viol || itlb_guarded); // RULE20
            if (instr_xlate_enable && fetch_req && itlb_hit &&
                (!itlb_page_valid || itlb_prot_viol || itlb_guarded))
                itlb_error_cause <= {!itlb_page_valid, itlb_prot_viol, itlb_guarded, 1'b0}; // RULE21
        end
    end
endmodule

// *** bench/dtlbro_asserts.sv ***
// checker: port-level properties of the tlb read-out and fault block
`timescale 1ns/10ps
module dtlbro_asserts (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // register port
    input wire logic spr_wr,
    input wire logic spr_rd,
    input wire logic [9:0] spr_num,
    input wire logic [31:0] spr_wdata,
    input wire logic [31:0] spr_rdata,
    // lookups
    input wire logic data_xlate_enable,
    input wire logic data_req,
    input wire logic data_write,
    input wire logic instr_xlate_enable,
    input wire logic fetch_req,
    input wire logic itlb_hit,
    input wire logic itlb_page_valid,
    input wire logic itlb_prot_viol,
    input wire logic itlb_guarded,
    // results
    input wire logic itlb_miss_irq,
    input wire logic dtlb_miss_irq,
    input wire logic itlb_error_irq,
    input wire logic dtlb_fault_irq,
    input wire logic [3:0] itlb_error_cause,
    input wire logic [3:0] current_space_field
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    // ==========
    // properties
    property p_imiss; fetch_req && instr_xlate_enable && !itlb_hit |=> itlb_miss_irq; endproperty
    a_imiss: assert property (p_imiss) else $error("missing instruction miss");
    property p_imiss_off; !(fetch_req && instr_xlate_enable && !itlb_hit) |=> !itlb_miss_irq; endproperty
    a_imiss_off: assert property (p_imiss_off) else $error("spurious instruction miss");
    property p_ierr; fetch_req && instr_xlate_enable && itlb_hit
        && (!itlb_page_valid || itlb_prot_viol || itlb_guarded) |=> itlb_error_irq; endproperty
    a_ierr: assert property (p_ierr) else $error("missing instruction error");
    property p_cause; itlb_error_irq |->
        itlb_error_cause == {!$past(itlb_page_valid), $past(itlb_prot_viol), $past(itlb_guarded), 1'b0}; endproperty
    a_cause: assert property (p_cause) else $error("wrong error cause");
    property p_dmiss_off; !(data_req && data_xlate_enable) |=> !dtlb_miss_irq; endproperty
    a_dmiss_off: assert property (p_dmiss_off) else $error("data miss without lookup");
    property p_fault_src; dtlb_fault_irq |-> $past(data_req && data_write && data_xlate_enable); endproperty
    a_fault_src: assert property (p_fault_src) else $error("fault without write");
    property p_cs; (spr_wr && spr_num == dtlbro_pkg::SPR_CURRENT_SPACE) ##1
        !(spr_wr && spr_num == dtlbro_pkg::SPR_CURRENT_SPACE) [*2] |->
        current_space_field == $past(spr_wdata[3:0], 2); endproperty
    a_cs: assert property (p_cs) else $error("current space not updated");
    property p_d0_rsv; spr_rd && spr_num == dtlbro_pkg::SPR_DATA_SNAPSHOT_0 |=> spr_rdata[1:0] == 2'h0; endproperty
    a_d0_rsv: assert property (p_d0_rsv) else $error("reserved bits set");
    c_snap: cover property (spr_wr && spr_num == dtlbro_pkg::SPR_TAG_SNAPSHOT);
    c_fault: cover property (dtlb_fault_irq);
    c_ierr: cover property (itlb_error_irq);
endmodule
bind dtlbro_top dtlbro_asserts u_chk (.*);

// *** bench/tb_top.sv ***
// testbench: snapshot read-out, lookups and fault pulses
`timescale 1ns/10ps
module tb_top;
    // ==========
    // signals
    logic ref_clk = 0, rst = 1, spr_wr = 0, spr_rd = 0, entry_load = 0;
    logic data_xlate_enable = 0, data_req = 0, data_write = 0, instr_xlate_enable = 0, fetch_req = 0;
    logic itlb_hit = 0, itlb_page_valid = 0, itlb_prot_viol = 0, itlb_guarded = 0;
    logic [9:0] spr_num = 10'h000;
    logic [31:0] spr_wdata = 32'h0, spr_rdata;
    logic [4:0] data_entry_index = 5'h00;
    logic [19:0] data_page = 20'h0;
    dtlbro_pkg::dtlbro_entry_t entry_in = '0;
    logic itlb_miss_irq, dtlb_miss_irq, itlb_error_irq, dtlb_fault_irq;
    logic [3:0] itlb_error_cause, current_space_field;
    int n_errors = 0, checks = 0, cyc = 0;
    logic [2:0] size_row [4] = '{3'h0, 3'h1, 3'h3, 3'h7};
    // fetch rows: xlate, hit, valid, prot, guarded, miss, error
    logic [6:0] f_row [6] = '{7'h52, 7'h10, 7'h61, 7'h79, 7'h75, 7'h70};
    dtlbro_top uut (.*);
    initial forever #5 ref_clk = ~ref_clk;
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            n_errors++;
            results();
        end
    end
    // ==========
    // helpers
    function automatic dtlbro_pkg::dtlbro_entry_t mk(int i);
        mk = '0;
        mk.effective_page_number = 20'(i + 1) << 16;
        mk.subpage_valid_flags = (i == 3) ? 4'h1 : 4'hF;
        mk.page_size_code = size_row[i % 4];
        mk.common_page_flag = i[0];
        mk.address_space_id = 4'(i);
        mk.real_page_number = 20'hABC00 + 20'(i);
        mk.apg = 4'(3 * i);
        mk.guarded = i[0];
        mk.write_through_attr = i[1];
        mk.no_cache_attr = ~i[0];
        mk.change = i[1];
        mk.entry_valid_flag = (i < 4);
        mk.priv_subpage_access = 4'h8 >> (i % 4);
        mk.priv_rw_type = ~i[1];
        mk.uperm = 8'h5A ^ 8'(i);
    endfunction
    function automatic logic [31:0] w(dtlbro_pkg::dtlbro_entry_t x, int k);
        logic [3:0] v;
        logic [3:0] s;
        v = {x.subpage_valid_flags[0], x.subpage_valid_flags[1], x.subpage_valid_flags[2],
            x.subpage_valid_flags[3]};
        s = {x.priv_subpage_access[0], x.priv_subpage_access[1], x.priv_subpage_access[2],
            x.priv_subpage_access[3]};
        case (k)
            0: w = {x.effective_page_number, v, x.page_size_code, x.common_page_flag, x.address_space_id};
            1: w = {x.real_page_number, x.page_size_code, ~x.apg, x.guarded,
                x.write_through_attr, x.no_cache_attr, 2'h0};
            default: w = {17'h0, x.change, x.entry_valid_flag, s, x.priv_rw_type, x.uperm};
        endcase
    endfunction
    task automatic chk(logic [31:0] got, logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic spr(logic wr, logic [9:0] n, logic [31:0] d);
        @(negedge ref_clk);
        {spr_wr, spr_rd, spr_num, spr_wdata} = {wr, ~wr, n, d};
        @(negedge ref_clk);
        {spr_wr, spr_rd} = 2'b00;
    endtask
    task automatic dacc(logic [19:0] p, logic wr, logic x, logic em, logic ef);
        @(negedge ref_clk);
        {data_req, data_write, data_xlate_enable, data_page} = {1'b1, wr, x, p};
        @(negedge ref_clk);
        data_req = 0;
        chk(32'({dtlb_miss_irq, dtlb_fault_irq}), 32'({em, ef}));
    endtask
    task automatic results();
        $display("errors %0d checks %0d", n_errors, checks);
        if (n_errors == 0 && checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // ==========
    // sequence
    initial begin
        repeat (5) @(negedge ref_clk);
        rst = 0;
        @(negedge ref_clk);
        chk(32'({itlb_miss_irq, dtlb_miss_irq, itlb_error_irq, dtlb_fault_irq}), 32'h0);
        chk(32'({itlb_error_cause, current_space_field}), 32'h0);
        chk(spr_rdata, 32'h0);
        for (int i = 0; i < 32; i++) begin
            @(negedge ref_clk);
            {data_entry_index, entry_in, entry_load} = {5'(i), mk(i), 1'b1};
        end
        @(negedge ref_clk);
        entry_load = 0;
        for (int r = 0; r < 4; r++) begin
            data_entry_index = 5'(r);
            spr(1, dtlbro_pkg::SPR_TAG_SNAPSHOT, ~32'(r));
            spr(1, dtlbro_pkg::SPR_DATA_SNAPSHOT_0, 32'h0);
            spr(1, dtlbro_pkg::SPR_DATA_SNAPSHOT_1, 32'h0);
            for (int k = 0; k < 3; k++) begin
                spr(0, dtlbro_pkg::SPR_TAG_SNAPSHOT + 10'(k), 32'h0);
                chk(spr_rdata, w(mk(r), k));
            end
        end
        @(negedge ref_clk);
        {entry_in, entry_load} = {mk(4), 1'b1};
        @(negedge ref_clk);
        entry_load = 0;
        spr(0, dtlbro_pkg::SPR_DATA_SNAPSHOT_0, 32'h0);
        chk(spr_rdata, w(mk(3), 1));
        spr(0, 10'h000, 32'h0);
        chk(spr_rdata, 32'h0);
        dacc(20'h10000, 1, 1, 0, 1);
        dacc(20'h30000, 1, 1, 1, 0);
        spr(1, dtlbro_pkg::SPR_CURRENT_SPACE, 32'h2);
        repeat (2) @(negedge ref_clk);
        chk(32'(current_space_field), 32'h2);
        spr(0, dtlbro_pkg::SPR_CURRENT_SPACE, 32'h0);
        chk(spr_rdata, 32'h2);
        dacc(20'h30000, 1, 1, 0, 0);
        dacc(20'h10000, 0, 1, 1, 0);
        dacc(20'h20000, 0, 1, 0, 0);
        dacc(20'h20003, 0, 1, 0, 0);
        dacc(20'h20004, 0, 1, 1, 0);
        dacc(20'h3007F, 0, 1, 0, 0);
        dacc(20'h30080, 0, 1, 1, 0);
        dacc(20'hF0000, 0, 1, 1, 0);
        dacc(20'hF0000, 0, 0, 0, 0);
        foreach (f_row[j]) begin
            @(negedge ref_clk);
            {instr_xlate_enable, itlb_hit, itlb_page_valid, itlb_prot_viol, itlb_guarded, fetch_req} = {f_row[j][6:2], 1'b1};
            @(negedge ref_clk);
            fetch_req = 0;
            chk(32'({itlb_miss_irq, itlb_error_irq}), 32'(f_row[j][1:0]));
            if (f_row[j][0])
                chk(32'(itlb_error_cause), 32'({~f_row[j][4], f_row[j][3:2], 1'b0}));
        end
        // mid-run reset: outputs clear, snapshot survives
        @(negedge ref_clk);
        rst = 1;
        repeat (2) @(negedge ref_clk);
        chk(32'({itlb_miss_irq, dtlb_miss_irq, itlb_error_irq, dtlb_fault_irq}), 32'h0);
        chk(32'({itlb_error_cause, current_space_field}), 32'h0);
        chk(spr_rdata, 32'h0);
        rst = 0;
        spr(0, dtlbro_pkg::SPR_TAG_SNAPSHOT, 32'h0);
        chk(spr_rdata, w(mk(3), 0));
        spr(0, dtlbro_pkg::SPR_CURRENT_SPACE, 32'h0);
        chk(spr_rdata, 32'h0);
        results();
    end
endmodule
